// File: ucib_defines.svh
// Purpose: Shared constants of one serial channel.
// Assumes: Included by its bare name.
// Notes:   Offsets, codes, reset values, tick counts and FIFO levels only.
`ifndef UCIB_DEFINES_SVH
`define UCIB_DEFINES_SVH
// Host access offsets.
`define UCIB_ADDR_DATA  3'h0
`define UCIB_ADDR_IEN   3'h1
`define UCIB_ADDR_ISR   3'h2
`define UCIB_ADDR_LCTL  3'h3
`define UCIB_ADDR_MCTL  3'h4
`define UCIB_ADDR_LSTAT 3'h5
`define UCIB_ADDR_MSTAT 3'h6
// Interrupt status codes, highest priority first.
`define UCIB_ISR_LINE   8'h06
`define UCIB_ISR_RXD    8'h04
`define UCIB_ISR_TOUT   8'h0C
`define UCIB_ISR_THRE   8'h02
`define UCIB_ISR_MODEM  8'h00
`define UCIB_ISR_NONE   8'h01
`define UCIB_ISR_FIFO   8'hC0
// Oversampling: last tick of a bit, and the half-bit tick.
`define UCIB_TICK_LAST  4'hF
`define UCIB_TICK_HALF  4'h7
// Receive trigger levels and FIFO capacity.
`define UCIB_TRIG_1     5'h01
`define UCIB_TRIG_4     5'h04
`define UCIB_TRIG_8     5'h08
`define UCIB_TRIG_14    5'h0E
`define UCIB_DEPTH      5'h10
// Reset values.
`define UCIB_DIV_RST    8'h00
`define UCIB_MDM_IDLE   4'hF
`endif

// File: ucib_pkg.sv
// Purpose: Types of the serial channel.
// Assumes: Used by ucib_channel only.
// Notes:   All channel state is one packed struct.
package ucib_pkg;
  // One-hot character phases, shared by transmitter and receiver.
  typedef enum logic [4:0] {
    UCIB_IDLE  = 5'h01,
    UCIB_START = 5'h02,
    UCIB_DATA  = 5'h04,
    UCIB_PAR   = 5'h08,
    UCIB_STOP  = 5'h10
  } ucib_phase_t;

  typedef struct packed {
    logic [15:0][7:0] tx_mem;
    logic [15:0][7:0] rx_mem;
    logic [3:0]       tx_wp, tx_rp, rx_wp, rx_rp;
    logic [4:0]       tx_cnt, rx_cnt;
    logic [3:0]       irq_enable_reg;
    logic [7:0]       div_lo, div_hi;
    logic [15:0]      baud_cnt;
    ucib_phase_t      tx_st, rx_st;
    logic [3:0]       tx_tick, tx_bit, rx_tick, rx_bit;
    logic [7:0]       tx_shift, rx_shift;
    logic             tx_par, tx_out, txp;
    logic             rx_s1, rx_s2, sel_s1, sel_s2;
    logic [3:0]       m_s1, m_s2, mprev, delta, mout;
    logic [9:0]       tout_cnt;
    logic             tout_flag, thre_flag, overrun;
    logic [7:0]       rdata;
  } ucib_state_t;
endpackage : ucib_pkg

// File: ucib_channel.sv
// Purpose: One serial channel: interrupts, time-out, baud, DMA modes, loopback.
// Assumes: clk is the reference clock; pins are asynchronous and synchronised.
// Notes:   Control bytes are plain ports; only divisor and enables are held here.
// Functional notes
// - Transmit-empty flag pending right after reset.
// - Status shows only highest pending source.
// - Data ready and time-out share enable bit 0; data ranks first.
// - Data interrupt once count reaches trigger.
// - No time-out while receive FIFO empty.
// - Time-out restarts at stop centre or read.
// - Time-out fires after four character times.
// - Select low: control bit 3 gates outputs.
// - Select high: interrupt output always enabled.
// - One baud generator for both directions.
// - Baud is reference over sixteen times divisor.
// - Divisor scales rate inversely, 1 is fastest.
// - FIFO control bit 3 picks DMA mode.
// - DMA mode 0 interrupts every transfer.
// - DMA mode 1 interrupts on trigger level.
// - Status bits 6, 5: empty, free location.
// - Loopback detaches modem pins, internal inputs.
// - Loopback ties transmitter to receiver internally.
// - Loopback maps bits 3:2 to RI/CD, 1:0 CTS/DSR.
// - Loopback keeps all interrupts working.
// - Loopback shows modem changes only in 3:0.
// - Line control bit 7 exposes divisor bytes.
// - Trigger level choices 1, 4, 8, 14.
`timescale 1ns/100ps
`include "ucib_defines.svh"
module ucib_channel import ucib_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [2:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic [7:0] line_control_reg,
  input  wire logic [7:0] fifo_control_reg,
  input  wire logic [7:0] modem_control_reg,
  input  wire logic       irq_output_select_pin,
  input  wire logic       rx_pin,
  input  wire logic       cts_pin_b,
  input  wire logic       dsr_pin_b,
  input  wire logic       ri_pin_b,
  input  wire logic       cd_pin_b,
  output logic      [7:0] host_rdata,
  output logic      [7:0] line_state_reg,
  output logic      [7:0] modem_state_reg,
  output logic      [7:0] irq_status,
  output logic            channel_irq_outputs,
  output logic            channel_irq_outputs_oe,
  output logic            tx_pin,
  output logic            rts_pin_b,
  output logic            dtr_pin_b,
  output logic            user_output_one_b,
  output logic            user_output_two_b
);

  // ----------------------------------------------------------------
  // Derived configuration
  // ----------------------------------------------------------------
  ucib_state_t s;          // Registered state.
  ucib_state_t n;          // Next state.
  logic        loop;       // Loopback mode.
  logic        dlab;       // Divisor bytes exposed.
  logic        fifo_en;    // FIFOs enabled.
  logic        dma1;       // DMA mode 1 selected.
  logic [3:0]  wlen;       // Data bits per character.
  logic [3:0]  nbits;      // Bits per whole character.
  logic [9:0]  tout_lim;   // Time-out length in ticks.
  logic [15:0] divisor;    // Baud divisor.
  logic        tick;       // One 16x baud tick.
  logic [4:0]  cap;        // Usable FIFO depth.
  logic [4:0]  trig;       // Receive trigger level.
  logic        rx_in;      // Receiver serial input.
  logic [3:0]  msr_now;    // CD, RI, DSR, CTS, active high.
  logic        rx_pop, tx_push, tx_pop, rx_push, rx_drop;
  logic        rx_lvl, p_line, p_rx, p_to, p_thre, p_mdm;

  assign loop    = modem_control_reg[4];
  assign dlab    = line_control_reg[7];
  assign fifo_en = fifo_control_reg[0];
  assign dma1    = fifo_control_reg[3] & fifo_en;
  assign wlen    = {2'h0, line_control_reg[1:0]} + 4'h5;
  assign nbits   = 4'h1 + wlen + {3'h0, line_control_reg[3]}
                   + (line_control_reg[2] ? 4'h2 : 4'h1);
  // Four characters of sixteen ticks per bit.
  assign tout_lim = {nbits, 6'h00};
  assign divisor  = {s.div_hi, s.div_lo};
  // One tick source feeds both directions.
  // Tick every divisor cycles, sixteen per bit.
  // A divisor of 1 ticks every cycle.
  // A count left above a freshly lowered divisor ticks at once instead of wrapping.
  assign tick = (divisor != 16'h0000) && (s.baud_cnt >= divisor - 16'h0001);
  // Without FIFOs the channel behaves as a single holding byte.
  assign cap  = fifo_en ? `UCIB_DEPTH : 5'h01;

  always_comb begin
    unique case (fifo_control_reg[7:6])
      2'h0: trig = `UCIB_TRIG_1;
      2'h1: trig = `UCIB_TRIG_4;
      2'h2: trig = `UCIB_TRIG_8;
      2'h3: trig = `UCIB_TRIG_14;
    endcase
  end

  // Receiver hears the transmitter in loopback.
  assign rx_in = loop ? s.tx_out : s.rx_s2;
  // Modem inputs come from internal sources in loopback.
  // Bit 3 to RI, bit 2 to CD, RTS to CTS, DTR to DSR.
  assign msr_now = loop ? {modem_control_reg[2], modem_control_reg[3],
                           modem_control_reg[0], modem_control_reg[1]}
                        : ~s.m_s2;

  // ----------------------------------------------------------------
  // Transfer strobes
  // ----------------------------------------------------------------
  // Data offset reaches the FIFOs only with bit 7 clear.
  assign rx_pop  = host_rd && (host_addr == `UCIB_ADDR_DATA) && !dlab
                   && (s.rx_cnt != 5'h00);
  assign tx_push = host_wr && (host_addr == `UCIB_ADDR_DATA) && !dlab
                   && (s.tx_cnt != cap);
  assign tx_pop  = tick && (s.tx_st == UCIB_IDLE) && (s.tx_cnt != 5'h00);
  // Stop bit centre is the last tick of the stop phase.
  assign rx_push = tick && (s.rx_st == UCIB_STOP)
                   && (s.rx_tick == `UCIB_TICK_LAST);
  assign rx_drop = rx_push && (s.rx_cnt == cap);

  // ----------------------------------------------------------------
  // Interrupt sources and priority
  // ----------------------------------------------------------------
  // Mode 0 raises on every received character.
  // Mode 1 raises on trigger level for block moves.
  // Trigger reached raises the data interrupt.
  assign rx_lvl = dma1 ? (s.rx_cnt >= trig) : (s.rx_cnt != 5'h00);
  // Both receive sources share enable bit 0.
  assign p_rx   = s.irq_enable_reg[0] & rx_lvl;
  // Time-out needs a non-empty receive FIFO.
  assign p_to   = s.irq_enable_reg[0] & s.tout_flag & (s.rx_cnt != 5'h00);
  assign p_line = s.irq_enable_reg[2] & s.overrun;
  assign p_thre = s.irq_enable_reg[1] & s.thre_flag;
  // Modem changes interrupt in loopback as well.
  assign p_mdm  = s.irq_enable_reg[3] & (|s.delta);

  // Report only the single highest pending source.
  always_comb begin
    if (p_line) begin
      irq_status = `UCIB_ISR_LINE;
    end else if (p_rx) begin
      irq_status = `UCIB_ISR_RXD;
    end else if (p_to) begin
      irq_status = `UCIB_ISR_TOUT;
    end else if (p_thre) begin
      irq_status = `UCIB_ISR_THRE;
    end else if (p_mdm) begin
      irq_status = `UCIB_ISR_MODEM;
    end else begin
      irq_status = `UCIB_ISR_NONE;
    end
    if (fifo_en) begin
      irq_status = irq_status | `UCIB_ISR_FIFO;
    end
  end

  assign channel_irq_outputs    = ~irq_status[0];
  // Control bit 3 gates the output when select is low.
  // Select high keeps the output enabled.
  assign channel_irq_outputs_oe = s.sel_s2 | modem_control_reg[3];

  // Bit 6 fully empty, bit 5 a free location.
  assign line_state_reg = {1'b0,
                           (s.tx_cnt == 5'h00) && (s.tx_st == UCIB_IDLE),
                           s.tx_cnt != cap, 3'h0, s.overrun,
                           s.rx_cnt != 5'h00};
  // Live levels hidden in loopback, changes stay visible.
  assign modem_state_reg = {loop ? 4'h0 : msr_now, s.delta};

  assign host_rdata        = s.rdata;
  assign tx_pin            = s.txp;
  assign dtr_pin_b         = s.mout[0];
  assign rts_pin_b         = s.mout[1];
  assign user_output_one_b = s.mout[2];
  assign user_output_two_b = s.mout[3];

  // Parity of the low w bits; even selects even parity.
  function automatic logic ucib_parity(input logic [7:0] d,
                                       input logic [3:0] w,
                                       input logic       even);
    logic [7:0] m;
    m = 8'hFF >> (4'h8 - w);
    return (^(d & m)) ^ ~even;
  endfunction : ucib_parity

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // Two flops on every asynchronous input before use.
    n.rx_s1  = rx_pin;
    n.rx_s2  = s.rx_s1;
    n.sel_s1 = irq_output_select_pin;
    n.sel_s2 = s.sel_s1;
    n.m_s1   = {cd_pin_b, ri_pin_b, dsr_pin_b, cts_pin_b};
    n.m_s2   = s.m_s1;
    n.mprev  = msr_now;
    // Divisor counter restarts on each tick.
    n.baud_cnt = tick ? 16'h0000 : s.baud_cnt + 16'h0001;
    if (divisor == 16'h0000) begin
      n.baud_cnt = 16'h0000;
    end
    // Pins held inactive while looped back.
    n.mout = loop ? `UCIB_MDM_IDLE : ~modem_control_reg[3:0];
    // Line output parked at mark in loopback.
    n.txp  = loop ? 1'b1 : s.tx_out;

    // Host writes.
    if (host_wr && (host_addr == `UCIB_ADDR_DATA)) begin
      // Bit 7 set reaches the low divisor byte.
      if (dlab) begin
        n.div_lo = host_wdata;
      end else if (tx_push) begin
        n.tx_mem[s.tx_wp] = host_wdata;
        n.tx_wp           = s.tx_wp + 4'h1;
      end
    end
    if (host_wr && (host_addr == `UCIB_ADDR_IEN)) begin
      // Bit 7 set reaches the high divisor byte.
      if (dlab) begin
        n.div_hi = host_wdata;
      end else begin
        n.irq_enable_reg = host_wdata[3:0];
      end
    end

    // Host reads; the byte is held until the next read.
    if (host_rd) begin
      unique case (host_addr)
        `UCIB_ADDR_DATA: n.rdata = dlab ? s.div_lo : s.rx_mem[s.rx_rp];
        `UCIB_ADDR_IEN:   n.rdata = dlab ? s.div_hi : {4'h0, s.irq_enable_reg};
        `UCIB_ADDR_ISR:   n.rdata = irq_status;
        `UCIB_ADDR_LCTL:  n.rdata = line_control_reg;
        `UCIB_ADDR_MCTL:  n.rdata = modem_control_reg;
        `UCIB_ADDR_LSTAT: n.rdata = line_state_reg;
        `UCIB_ADDR_MSTAT: n.rdata = modem_state_reg;
        default:         n.rdata = 8'h00;
      endcase
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + 4'h1;
    end

    // Transmitter, advanced on baud ticks only.
    if (tick) begin
      unique case (s.tx_st)
        UCIB_IDLE: begin
          if (tx_pop) begin
            n.tx_shift = s.tx_mem[s.tx_rp];
            n.tx_par   = ucib_parity(s.tx_mem[s.tx_rp], wlen,
                                     line_control_reg[4]);
            n.tx_rp    = s.tx_rp + 4'h1;
            n.tx_out   = 1'b0;
            n.tx_tick  = 4'h0;
            n.tx_st    = UCIB_START;
          end
        end
        default: begin
          n.tx_tick = s.tx_tick + 4'h1;
          if (s.tx_tick == `UCIB_TICK_LAST) begin
            unique case (s.tx_st)
              UCIB_START: begin
                n.tx_out = s.tx_shift[0];
                n.tx_bit = 4'h0;
                n.tx_st  = UCIB_DATA;
              end
              UCIB_DATA: begin
                if (s.tx_bit == wlen - 4'h1) begin
                  n.tx_out = line_control_reg[3] ? s.tx_par : 1'b1;
                  n.tx_bit = 4'h0;
                  n.tx_st  = line_control_reg[3] ? UCIB_PAR : UCIB_STOP;
                end else begin
                  n.tx_shift = s.tx_shift >> 1;
                  n.tx_out   = s.tx_shift[1];
                  n.tx_bit   = s.tx_bit + 4'h1;
                end
              end
              UCIB_PAR: begin
                n.tx_out = 1'b1;
                n.tx_st  = UCIB_STOP;
              end
              default: begin
                // Two stop bits when bit 2 is set.
                if (s.tx_bit == {3'h0, line_control_reg[2]}) begin
                  n.tx_st = UCIB_IDLE;
                end else begin
                  n.tx_bit = s.tx_bit + 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end

    // Receiver; the start half-bit puts later samples at bit centres.
    if (tick) begin
      n.rx_tick = s.rx_tick + 4'h1;
      unique case (s.rx_st)
        UCIB_IDLE: begin
          n.rx_tick = 4'h0;
          if (!rx_in) begin
            n.rx_st = UCIB_START;
          end
        end
        UCIB_START: begin
          // A short low pulse is a false start and is ignored.
          if (s.rx_tick == `UCIB_TICK_HALF) begin
            n.rx_tick = 4'h0;
            n.rx_bit  = 4'h0;
            n.rx_st   = rx_in ? UCIB_IDLE : UCIB_DATA;
          end
        end
        UCIB_DATA: begin
          if (s.rx_tick == `UCIB_TICK_LAST) begin
            n.rx_shift = {rx_in, s.rx_shift[7:1]};
            n.rx_bit   = s.rx_bit + 4'h1;
            if (s.rx_bit == wlen - 4'h1) begin
              n.rx_st = line_control_reg[3] ? UCIB_PAR : UCIB_STOP;
            end
          end
        end
        UCIB_PAR: begin
          if (s.rx_tick == `UCIB_TICK_LAST) begin
            n.rx_st = UCIB_STOP;
          end
        end
        default: begin
          if (rx_push) begin
            n.rx_st = UCIB_IDLE;
          end
        end
      endcase
    end
    // A full FIFO drops the new character and flags overrun.
    if (rx_push && !rx_drop) begin
      n.rx_mem[s.rx_wp] = s.rx_shift >> (4'h8 - wlen);
      n.rx_wp           = s.rx_wp + 4'h1;
    end
    n.rx_cnt = s.rx_cnt + {4'h0, rx_push && !rx_drop} - {4'h0, rx_pop};
    n.tx_cnt = s.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

    // Restart on stop centre or host read.
    if (rx_push || rx_pop) begin
      n.tout_cnt = 10'h000;
    end else if (tick && (s.rx_cnt != 5'h00) && (s.tout_cnt != tout_lim)) begin
      n.tout_cnt = s.tout_cnt + 10'h001;
    end
    // Flag once the count reaches four characters.
    n.tout_flag = (s.tout_flag || (s.tout_cnt == tout_lim))
                  && (s.rx_cnt != 5'h00) && !rx_pop;

    // Sticky flags; a new event wins over a clear in the same cycle.
    n.overrun = (s.overrun && !(host_rd && (host_addr == `UCIB_ADDR_LSTAT)))
                || rx_drop;
    n.delta = (s.delta & ~{4{host_rd && (host_addr == `UCIB_ADDR_MSTAT)}})
              | {s.mprev[3] ^ msr_now[3], s.mprev[2] & ~msr_now[2],
                 s.mprev[1] ^ msr_now[1], s.mprev[0] ^ msr_now[0]};
    // Mode 0 signals each freed transmit location.
    // Mode 1 signals only when the FIFO drained.
    n.thre_flag = (s.thre_flag && !tx_push
                   && !(host_rd && (host_addr == `UCIB_ADDR_ISR)
                        && (irq_status[3:0] == `UCIB_ISR_THRE)))
                  || (tx_pop && (!dma1 || (s.tx_cnt == 5'h01)));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s           <= '0;
      s.tx_st     <= UCIB_IDLE;
      s.rx_st     <= UCIB_IDLE;
      s.tx_out    <= 1'b1;
      s.txp       <= 1'b1;
      s.rx_s1     <= 1'b1;
      s.rx_s2     <= 1'b1;
      s.m_s1      <= `UCIB_MDM_IDLE;
      s.m_s2      <= `UCIB_MDM_IDLE;
      s.mout      <= `UCIB_MDM_IDLE;
      s.div_lo    <= `UCIB_DIV_RST;
      s.div_hi    <= `UCIB_DIV_RST;
      // Transmit holding empty is pending out of reset.
      s.thre_flag <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_thre_after_reset: assert property ($rose(rst_b) |-> s.thre_flag)
    else $error("Transmit empty flag not set after reset.");
  a_isr_single_top: assert property (p_line |-> irq_status[3:0] == 4'h6)
    else $error("Line status not reported first.");
  a_rx_shared_en: assert property (!s.irq_enable_reg[0]
    |-> irq_status[3:0] != 4'h4 && irq_status[3:0] != 4'hC)
    else $error("Receive interrupt while bit 0 is clear.");
  a_rx_trigger_hit: assert property (dma1 && s.irq_enable_reg[0] && !p_line
    && s.rx_cnt >= trig |-> irq_status[3:0] == 4'h4)
    else $error("Trigger reached without data interrupt.");
  a_tout_not_empty: assert property (p_to |-> line_state_reg[0])
    else $error("Time-out with empty receive FIFO.");
  a_tout_restart: assert property (ce && (rx_push || rx_pop)
    |=> s.tout_cnt == 10'h000)
    else $error("Time-out counter not restarted.");
  a_tout_length: assert property ($rose(s.tout_flag)
    |-> $past(s.tout_cnt) == $past(tout_lim))
    else $error("Time-out fired at wrong count.");
  a_irq_sel_high: assert property (s.sel_s2 |-> channel_irq_outputs_oe)
    else $error("Interrupt output disabled with select high.");
  a_baud_period: assert property (ce && tick && divisor > 16'h0002
    && $stable(divisor) |=> !tick || $changed(divisor))
    else $error("Baud ticks closer than divisor.");
  a_dma0_each: assert property (fifo_en && !dma1 && s.irq_enable_reg[0] && !p_line
    && s.rx_cnt != 5'h00 |-> channel_irq_outputs)
    else $error("Mode 0 character without interrupt.");
  a_lsr_empty: assert property (line_state_reg[6] |-> line_state_reg[5])
    else $error("Empty transmitter without free location.");
  a_loop_tx_mark: assert property (ce && loop |=> tx_pin)
    else $error("Transmit pin driven in loopback.");
  a_loop_msr_hi: assert property (loop |-> modem_state_reg[7:4] == 4'h0)
    else $error("Modem levels visible in loopback.");

  c_loop_char: cover property (loop && rx_push && !rx_drop);
  c_tout_rise: cover property ($rose(s.tout_flag));
  c_dma1_irq: cover property (dma1 && irq_status[3:0] == 4'h4);
  c_overrun: cover property (rx_drop);

endmodule : ucib_channel

// File: ucib_remote.sv
// Purpose: Remote serial device facing one channel.
// Assumes: Divisor 1, so one bit lasts 16 clocks; 8N1 frames.
// Notes:   Line idles high (mark) between frames.
`timescale 1ns/100ps
module ucib_remote (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  // Mark level at start, so the receiver sees no false start bit.
  initial line_out = 1'b1;

  // Send start bit, eight data bits LSB first, one stop bit.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (16) @(posedge clk);
      #1;
    end
  endtask : send

  // Capture one frame at bit centres; the start wait is bounded.
  task automatic recv(output logic [7:0] b);
    b = 'x;
    for (int n = 0; n < 400 && line_in !== 1'b0; n++) @(posedge clk);
    // No start bit in time: the byte stays unknown, so the compare fails.
    if (line_in !== 1'b0) return;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      b[i] = line_in;
    end
  endtask : recv
endmodule : ucib_remote

// File: uart_channel_irq_baud_dma_loopback_tb.sv
// Purpose: Self-checking bench of one serial channel.
// Assumes: Divisor 1, one bit is 16 clocks; data from a fixed seed.
// Notes:   Modem pins stay inactive; loopback drives the modem inputs.
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module uart_channel_irq_baud_dma_loopback_tb;
  logic       clk, rst_b, wr, rd, sel, rxl, txl, irq, oe, rts_b, dtr_b, o1_b, o2_b;
  logic [2:0] adr;
  logic [7:0] wd, lctl, fctl, mctl, rdat, lstat, mstat, isr, b, got;
  logic [7:0] q [4];
  integer     seed = 83254, error_cnt = 0, checked = 0;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  ucib_channel u_ucib_channel (.clk(clk), .rst_b(rst_b), .ce(1'b1), .host_wr(wr),
    .host_rd(rd), .host_addr(adr), .host_wdata(wd), .line_control_reg(lctl),
    .fifo_control_reg(fctl), .modem_control_reg(mctl), .irq_output_select_pin(sel),
    .rx_pin(rxl), .cts_pin_b(1'b1), .dsr_pin_b(1'b1), .ri_pin_b(1'b1), .cd_pin_b(1'b1),
    .host_rdata(rdat), .line_state_reg(lstat), .modem_state_reg(mstat), .irq_status(isr),
    .channel_irq_outputs(irq), .channel_irq_outputs_oe(oe), .tx_pin(txl),
    .rts_pin_b(rts_b), .dtr_pin_b(dtr_b), .user_output_one_b(o1_b),
    .user_output_two_b(o2_b));
  ucib_remote u_ucib_remote (.clk(clk), .line_in(txl), .line_out(rxl));

  // Host access: strobe for one edge, then one idle edge before the next.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    adr = a;
    wd  = d;
    wr  = w;
    rd  = ~w;
    @(posedge clk) #1;
    wr  = 1'b0;
    rd  = 1'b0;
    @(posedge clk) #1;
  endtask : acc

  // Bounded wait for an interrupt code; running out counts a mismatch.
  task automatic wait_isr(input logic [7:0] e, input int n);
    for (int i = 0; i < n && isr !== e; i++) @(posedge clk) #1;
    `CHK("isr", e, isr)
  endtask : wait_isr

  // Time-out length in clocks at divisor 1: four characters of 16 ticks a bit.
  function automatic int tout_clks(input int wl, input int par, input int stp);
    return 64 * (1 + wl + par + stp);
  endfunction : tout_clks

  task automatic results;
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Watchdog: a hang ends in the common report.
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    {wr, rd, adr, wd, sel, mctl} = '0;
    lctl  = 8'h80;
    fctl  = 8'h01;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    `CHK("lstat", 8'h60, lstat)
    `CHK("isr", 8'hC1, isr)
    `CHK("oe", 1'b0, oe)
    acc(1, 3'h0, 8'h01);
    acc(1, 3'h1, 8'h00);
    lctl = 8'h03;
    acc(1, 3'h1, 8'h02);
    `CHK("isr", 8'hC2, isr)
    `CHK("irq", 1'b1, irq)
    mctl = 8'h08;
    @(posedge clk) #1;
    `CHK("oe", 1'b1, oe)
    `CHK("pins", 4'hE, {rts_b, dtr_b, o1_b, o2_b})
    mctl = 8'h00;
    sel = 1'b1;
    repeat (3) @(posedge clk) #1;
    `CHK("oe", 1'b1, oe)
    sel = 1'b0;
    b = 8'($random(seed));
    fork
      acc(1, 3'h0, b);
      u_ucib_remote.recv(got);
    join
    `CHK("txd", b, got)
    // Mode 0 with trigger 4: each character interrupts by itself.
    fctl = 8'h41;
    acc(1, 3'h1, 8'h03);
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      u_ucib_remote.send(b);
      wait_isr(8'hC4, 40);
      `CHK("lstat0", 1'b1, lstat[0])
      acc(0, 3'h0, 8'h00);
      `CHK("rxd", b, rdat)
      `CHK("isr", 8'hC2, isr)
    end
    // Mode 1, trigger 4: one character only times out.
    fctl = 8'h49;
    acc(1, 3'h1, 8'h01);
    b = 8'($random(seed));
    u_ucib_remote.send(b);
    repeat (tout_clks(8, 0, 1) - 20) @(posedge clk) #1;
    `CHK("isr", 8'hC1, isr)
    wait_isr(8'hCC, 100);
    acc(0, 3'h0, 8'h00);
    `CHK("rxd", b, rdat)
    for (int k = 0; k < 4; k++) begin
      q[k] = 8'($random(seed));
      u_ucib_remote.send(q[k]);
      if (k == 2) begin
        `CHK("isr", 8'hC1, isr)
        `CHK("irq", 1'b0, irq)
      end
    end
    wait_isr(8'hC4, 40);
    for (int k = 0; k < 4; k++) begin
      acc(0, 3'h0, 8'h00);
      `CHK("rxd", q[k], rdat)
    end
    repeat (tout_clks(8, 0, 1) + 60) @(posedge clk) #1;
    `CHK("isr", 8'hC1, isr)
    // Divisor 3 for a while: spaced ticks, and data offset writes reach the divisor only.
    lctl = 8'h83;
    acc(1, 3'h0, 8'h03);
    repeat (12) @(posedge clk) #1;
    acc(1, 3'h0, 8'h01);
    lctl = 8'h03;
    `CHK("lstat", 8'h60, lstat)
    // Loopback: modem inputs from control bits, data returns internally.
    fctl = 8'h01;
    mctl = 8'h10;
    acc(0, 3'h6, 8'h00);
    mctl = 8'h13;
    repeat (4) @(posedge clk) #1;
    `CHK("mstat", 8'h03, mstat)
    `CHK("pins", 4'hF, {rts_b, dtr_b, o1_b, o2_b})
    b = 8'($random(seed));
    acc(1, 3'h0, b);
    `CHK("txl", 1'b1, txl)
    wait_isr(8'hC4, 300);
    acc(0, 3'h0, 8'h00);
    `CHK("loop", b, rdat)
    results();
  end
endmodule : uart_channel_irq_baud_dma_loopback_tb
